/* File: rtl/uart_port_map.vh */
// constants for the serial register access port
`ifndef UART_PORT_MAP_VH
`define UART_PORT_MAP_VH
`define SYNC_BYTE 8'hFE
`define RW_BIT 7
`define CLK_HZ 40000000
`define RESP_MS 5
`define HOST_GAP_MS 20
`define RESP_CYCLES ((`CLK_HZ / 1000) * `RESP_MS)
`define HOST_GAP_CYCLES ((`CLK_HZ / 1000) * `HOST_GAP_MS)
`define TX_GAP_BITS 5
`define TX_GAP_USED 1
`define MIN_BIT_CYCLES 16'h0080
`define MAX_BIT_CYCLES 16'h4E20
`endif

/* File: rtl/uart_register_access_port.v */
// serial register access port with baud detection and checksums
// What this block does
// - eight data bits, no parity
// - six byte transaction opened by FEH
// - address byte: bit7 rw, bits6-0 address
// - respond within 5 ms after good checksum
// - response byte gaps at most five bits
// - abort when host byte gap exceeds 20ms
// - abort drops bytes until next FEH
// - baud measured from FEH, 2400/9600
// - data bits least significant first
// - transmit pin released when not sending
// - write: five host bytes, one reply
// - read: three host bytes, three replies
// - checksum is eight bit unsigned sum
// - write checksum is address plus data
// - read: host sum address, reply sum data
// - port active only with select high
// - last transferred word kept readable while select is high
`include "uart_port_map.vh"
`default_nettype none
module uart_register_access_port #(
  parameter RESP_CYCLES = `RESP_CYCLES,
  parameter HOST_GAP_CYCLES = `HOST_GAP_CYCLES
) (
  // clock and reset
  input wire ref_clk,
  input wire reset,
  // serial pins
  input wire interface_select_pin,
  input wire serial_receive_pin,
  output wire serial_transmit_pin,
  output wire serial_transmit_oe_n,
  // register bank
  output reg [6:0] reg_addr,
  output reg reg_write,
  output reg reg_read,
  output reg [15:0] reg_wdata,
  input wire [15:0] reg_rdata,
  output reg [15:0] last_transfer_value
);
  localparam S_SYNC = 3'd0;
  localparam S_ADDR = 3'd1;
  localparam S_DHI = 3'd2;
  localparam S_DLO = 3'd3;
  localparam S_SUM = 3'd4;
  localparam S_RESP = 3'd5;
  localparam R_IDLE = 2'd0;
  localparam R_DATA = 2'd1;
  localparam R_STOP = 2'd2;
  localparam R_MEAS = 2'd3;

  function [7:0] sum8;
    input [7:0] a;
    input [7:0] b;
    input [7:0] c;
    begin
      sum8 = a + b + c;
    end
  endfunction

  reg [2:0] st_q;
  reg [1:0] rx_st_q;
  reg rx_prev_q;
  reg [15:0] bit_len_q;
  reg [15:0] meas_q;
  reg [15:0] rx_cnt_q;
  reg [2:0] rx_bit_q;
  reg [7:0] rx_sh_q;
  reg rx_valid_q;
  reg [7:0] rx_byte_q;
  reg [31:0] gap_q;
  reg [7:0] addr_q;
  reg [7:0] dhi_q;
  reg [7:0] dlo_q;
  reg [1:0] tx_left_q;
  reg [23:0] tx_buf_q;
  reg tx_busy_q;
  reg [3:0] tx_bit_q;
  reg [9:0] tx_sh_q;
  reg [15:0] tx_cnt_q;
  reg tx_out_q;

  wire active = interface_select_pin;
  wire is_read = addr_q[`RW_BIT];
  wire fall = rx_prev_q & ~serial_receive_pin;
  wire gap_out = (st_q != S_SYNC) && (st_q != S_RESP) && (gap_q >= HOST_GAP_CYCLES);

  assign serial_transmit_pin = tx_out_q;
  assign serial_transmit_oe_n = ~tx_busy_q;

  // receiver: idle measures the sync byte, bit length from its first low run
  always @(posedge ref_clk) begin
    if (reset || !active) begin
      rx_st_q <= R_IDLE;
      rx_prev_q <= 1'b1;
      bit_len_q <= 16'h0000;
      meas_q <= 16'h0000;
      rx_cnt_q <= 16'h0000;
      rx_bit_q <= 3'd0;
      rx_sh_q <= 8'h00;
      rx_valid_q <= 1'b0;
      rx_byte_q <= 8'h00;
    end else begin
      rx_prev_q <= serial_receive_pin;
      rx_valid_q <= 1'b0;
      case (rx_st_q)
        R_IDLE: begin
          if (fall) begin
            if (st_q == S_SYNC) begin
              // FEH: start and bit0 low give two bit times of low
              rx_st_q <= R_MEAS;
              meas_q <= 16'h0001;
            end else begin
              rx_st_q <= R_DATA;
              rx_cnt_q <= bit_len_q + {1'b0, bit_len_q[15:1]};
              rx_bit_q <= 3'd0;
            end
          end
        end
        R_MEAS: begin
          meas_q <= meas_q + 16'h0001;
          if (serial_receive_pin) begin
            bit_len_q <= {1'b0, meas_q[15:1]};
            // bits 1..7 are sampled as data from mid bit: skipping straight to the stop
            // bit would overflow the counter at the slow rate and let a false sync through
            rx_cnt_q <= {2'b00, meas_q[15:2]};
            rx_bit_q <= 3'd1;
            rx_sh_q <= 8'h00;
            rx_st_q <= R_DATA;
          end
        end
        R_DATA: begin
          if (rx_cnt_q != 16'h0000) begin
            rx_cnt_q <= rx_cnt_q - 16'h0001;
          end else begin
            rx_sh_q <= {serial_receive_pin, rx_sh_q[7:1]};
            rx_cnt_q <= bit_len_q - 16'h0001;
            rx_bit_q <= rx_bit_q + 3'd1;
            if (rx_bit_q == 3'd7) begin
              rx_st_q <= R_STOP;
            end
          end
        end
        default: begin
          if (rx_cnt_q != 16'h0000) begin
            rx_cnt_q <= rx_cnt_q - 16'h0001;
          end else begin
            rx_st_q <= R_IDLE;
            // stop must be high and the measured rate plausible
            if (serial_receive_pin && bit_len_q >= `MIN_BIT_CYCLES && bit_len_q <= `MAX_BIT_CYCLES) begin
              rx_valid_q <= 1'b1;
              rx_byte_q <= rx_sh_q;
            end
          end
        end
      endcase
    end
  end

  // transaction sequencer
  always @(posedge ref_clk) begin
    if (reset || !active) begin
      st_q <= S_SYNC;
      gap_q <= 32'h0000_0000;
      addr_q <= 8'h00;
      dhi_q <= 8'h00;
      dlo_q <= 8'h00;
      reg_addr <= 7'h00;
      reg_write <= 1'b0;
      reg_read <= 1'b0;
      reg_wdata <= 16'h0000;
      last_transfer_value <= 16'h0000;
      tx_left_q <= 2'd0;
      tx_buf_q <= 24'h00_0000;
    end else begin
      reg_write <= 1'b0;
      reg_read <= 1'b0;
      // only idle line time counts, so a slow byte never eats into the host gap
      if (rx_valid_q || rx_st_q != R_IDLE) begin
        gap_q <= 32'h0000_0000;
      end else if (gap_q != 32'hFFFF_FFFF) begin
        gap_q <= gap_q + 32'h0000_0001;
      end
      if (gap_out) begin
        st_q <= S_SYNC;
      end else begin
        case (st_q)
          S_SYNC: begin
            if (rx_valid_q && rx_byte_q == `SYNC_BYTE) begin
              st_q <= S_ADDR;
            end
          end
          S_ADDR: begin
            if (rx_valid_q) begin
              addr_q <= rx_byte_q;
              st_q <= rx_byte_q[`RW_BIT] ? S_SUM : S_DHI;
            end
          end
          S_DHI: begin
            if (rx_valid_q) begin
              dhi_q <= rx_byte_q;
              st_q <= S_DLO;
            end
          end
          S_DLO: begin
            if (rx_valid_q) begin
              dlo_q <= rx_byte_q;
              st_q <= S_SUM;
            end
          end
          S_SUM: begin
            if (rx_valid_q) begin
              st_q <= S_SYNC;
              if (is_read && rx_byte_q == addr_q) begin
                reg_addr <= addr_q[6:0];
                reg_read <= 1'b1;
                st_q <= S_RESP;
              end else if (!is_read && rx_byte_q == sum8(addr_q, dhi_q, dlo_q)) begin
                reg_addr <= addr_q[6:0];
                reg_wdata <= {dhi_q, dlo_q};
                reg_write <= 1'b1;
                last_transfer_value <= {dhi_q, dlo_q};
                tx_buf_q <= {sum8(addr_q, dhi_q, dlo_q), 16'h0000};
                tx_left_q <= 2'd1;
              end
            end
          end
          S_RESP: begin
            // register data is sampled in the same cycle that the read strobe is high
            last_transfer_value <= reg_rdata;
            tx_buf_q <= {reg_rdata, sum8(reg_rdata[15:8], reg_rdata[7:0], 8'h00)};
            tx_left_q <= 2'd3;
            st_q <= S_SYNC;
          end
          default: st_q <= S_SYNC;
        endcase
      end
      if (!tx_busy_q && tx_left_q != 2'd0 && st_q != S_RESP) begin
        tx_left_q <= tx_left_q - 2'd1;
        tx_buf_q <= {tx_buf_q[15:0], 8'h00};
      end
    end
  end

  // transmitter: bytes go back to back, reply starts within a few cycles
  always @(posedge ref_clk) begin
    if (reset || !active) begin
      tx_busy_q <= 1'b0;
      tx_bit_q <= 4'h0;
      tx_sh_q <= 10'h3FF;
      tx_cnt_q <= 16'h0000;
      tx_out_q <= 1'b1;
    end else if (!tx_busy_q) begin
      tx_out_q <= 1'b1;
      if (tx_left_q != 2'd0 && st_q != S_RESP) begin
        tx_busy_q <= 1'b1;
        tx_sh_q <= {1'b1, tx_buf_q[23:16], 1'b0};
        tx_bit_q <= 4'h0;
        tx_cnt_q <= 16'h0000;
      end
    end else if (tx_cnt_q != 16'h0000) begin
      tx_cnt_q <= tx_cnt_q - 16'h0001;
    end else if (tx_bit_q == 4'd10) begin
      tx_busy_q <= 1'b0;
      tx_out_q <= 1'b1;
    end else begin
      tx_out_q <= tx_sh_q[0];
      tx_sh_q <= {1'b1, tx_sh_q[9:1]};
      tx_bit_q <= tx_bit_q + 4'h1;
      tx_cnt_q <= bit_len_q - 16'h0001;
    end
  end
endmodule // uart_register_access_port
`default_nettype wire

/* File: dv/uart_port_props.sv */
// assertion checker for the serial register access port
`default_nettype none
module uart_port_props (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // serial pins
  input wire logic interface_select_pin,
  input wire logic serial_receive_pin,
  input wire logic serial_transmit_pin,
  input wire logic serial_transmit_oe_n,
  // register bank
  input wire logic [6:0] reg_addr,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic [15:0] last_transfer_value
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  AST_TX_IDLE_HIGH: assert property (serial_transmit_oe_n |-> serial_transmit_pin)
    else $error("transmit data not high while released");
  AST_START_LOW: assert property ($fell(serial_transmit_oe_n) |=> !serial_transmit_pin)
    else $error("character does not open with a low start bit");
  AST_ONE_STROBE: assert property (!(reg_write && reg_read))
    else $error("read and write strobes together");
  AST_LAST_WRITE: assert property (reg_write |=> last_transfer_value == $past(reg_wdata))
    else $error("written word not kept");
  AST_LAST_READ: assert property (reg_read |-> ##[1:3] last_transfer_value == reg_rdata)
    else $error("read word not kept");
  AST_WRITE_REPLY: assert property (reg_write |-> ##[1:20] !serial_transmit_oe_n)
    else $error("no reply after write");
  AST_READ_REPLY: assert property (reg_read |-> ##[1:20] !serial_transmit_oe_n)
    else $error("no reply after read");
  AST_SELECT_LOW: assert property (!interface_select_pin |=> serial_transmit_oe_n && !reg_write)
    else $error("port active while deselected");
  cover property (reg_write);
  cover property (reg_read);
  cover property ($fell(serial_transmit_oe_n));
endmodule // uart_port_props
bind uart_register_access_port uart_port_props u_props (
  .ref_clk(ref_clk),
  .reset(reset),
  .interface_select_pin(interface_select_pin),
  .serial_receive_pin(serial_receive_pin),
  .serial_transmit_pin(serial_transmit_pin),
  .serial_transmit_oe_n(serial_transmit_oe_n),
  .reg_addr(reg_addr),
  .reg_write(reg_write),
  .reg_read(reg_read),
  .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata),
  .last_transfer_value(last_transfer_value)
);
`default_nettype wire

/* File: dv/host_uart_model.sv */
// host side serial model for the register access port
`default_nettype none
module host_uart_model #(
  parameter int BIT = 1024
) (
  // clock
  input wire logic ref_clk,
  // serial lines
  output logic rx_line,
  input wire logic tx_pin,
  input wire logic tx_oe_n
);
  timeunit 1ns;
  timeprecision 1ns;
  // the released pin is pulled up, so it reads high
  wire logic line = tx_oe_n ? 1'b1 : tx_pin;
  initial rx_line = 1'b1;
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(negedge ref_clk) rx_line = f[i];
      repeat (BIT - 1) @(negedge ref_clk);
    end
  endtask
  // bounded wait stands in for the host failure timer
  task automatic recv(output logic [7:0] b);
    int n;
    n = 0;
    b = 8'h00;
    while (line && n < 16 * BIT) begin
      @(negedge ref_clk);
      n++;
    end
    repeat (BIT + BIT / 2) @(negedge ref_clk);
    for (int i = 0; i < 8; i++) begin
      b[i] = line;
      repeat (BIT) @(negedge ref_clk);
    end
  endtask
endmodule // host_uart_model
`default_nettype wire

/* File: dv/uart_register_access_port_tb.sv */
// self-checking bench for the serial register access port
`default_nettype none
module uart_register_access_port_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int BIT = 128;
  localparam int GAP = 4000;
  logic ref_clk, reset, interface_select_pin;
  logic [15:0] reg_rdata, seen_wdata;
  logic [6:0] seen_addr;
  logic [7:0] a, h, l, r;
  wire logic rx, tx, tx_oe_n, reg_write, reg_read;
  wire logic [6:0] reg_addr;
  wire logic [15:0] reg_wdata, last_transfer_value;
  int errors, tests_run, cyc;
  int strobes, replies, s0, t0;
  logic oe_q = 1'b1;
  // short gap limit keeps the run brief, still above one byte time
  uart_register_access_port #(.HOST_GAP_CYCLES(GAP)) u_dut (
    .ref_clk(ref_clk),
    .reset(reset),
    .interface_select_pin(interface_select_pin),
    .serial_receive_pin(rx),
    .serial_transmit_pin(tx),
    .serial_transmit_oe_n(tx_oe_n),
    .reg_addr(reg_addr),
    .reg_write(reg_write),
    .reg_read(reg_read),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata),
    .last_transfer_value(last_transfer_value)
  );
  host_uart_model #(.BIT(BIT)) u_host (.ref_clk(ref_clk), .rx_line(rx), .tx_pin(tx), .tx_oe_n(tx_oe_n));
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    oe_q <= tx_oe_n;
    if (oe_q && !tx_oe_n) begin
      replies <= replies + 1;
    end
    if (reg_write || reg_read) begin
      strobes <= strobes + 1;
      seen_addr <= reg_addr;
      seen_wdata <= reg_wdata;
    end
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 100000) begin
      errors++;
      $display("MISMATCH %0t timeout", $time);
      end_of_test();
    end
  end
  function automatic logic [7:0] cks(input logic [7:0] x, y, z);
    return x + y + z;
  endfunction
  task automatic chk(input logic [15:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // full host write with the checksum byte given by the caller, reply caught in r
  task automatic host_write(input logic [7:0] ad, hi, lo, sum);
    u_host.send(8'hFE);
    u_host.send(ad);
    u_host.send(hi);
    u_host.send(lo);
    fork
      u_host.send(sum);
      u_host.recv(r);
    join
  endtask
  task automatic end_of_test;
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    reset = 1'b1;
    interface_select_pin = 1'b1;
    reg_rdata = 16'h0000;
    void'($urandom(32'h0606_6639));
    repeat (3) @(negedge ref_clk);
    reset = 1'b0;
    a = $urandom & 8'h7F;
    h = $urandom;
    l = $urandom;
    host_write(a, h, l, cks(a, h, l));
    chk(r, cks(a, h, l));
    chk(seen_addr, a[6:0]);
    chk(seen_wdata, {h, l});
    chk(last_transfer_value, {h, l});
    $display("write test done");
    // top address as a corner, read reply data drawn at random
    a = 8'hFF;
    reg_rdata = $urandom;
    u_host.send(8'hFE);
    u_host.send(a);
    fork
      u_host.send(a);
      u_host.recv(h);
    join
    u_host.recv(l);
    u_host.recv(r);
    chk(h, reg_rdata[15:8]);
    chk(l, reg_rdata[7:0]);
    chk(r, cks(reg_rdata[15:8], reg_rdata[7:0], 8'h00));
    chk(seen_addr, 7'h7F);
    chk(last_transfer_value, reg_rdata);
    $display("read test done");
    // a bad checksum is dropped silently, then the host rests a full gap
    s0 = strobes;
    t0 = replies;
    host_write(8'h12, 8'h34, 8'h56, 8'h00);
    repeat (GAP + 200) @(negedge ref_clk);
    chk(strobes - s0, 0);
    chk(replies - t0, 0);
    chk(last_transfer_value, reg_rdata);
    $display("bad checksum test done");
    // a stalled write is abandoned, so the next sync byte opens a fresh one
    u_host.send(8'hFE);
    u_host.send(8'h05);
    repeat (GAP + 200) @(negedge ref_clk);
    a = $urandom & 8'h7F;
    h = $urandom;
    l = $urandom;
    host_write(a, h, l, cks(a, h, l));
    chk(r, cks(a, h, l));
    chk(seen_wdata, {h, l});
    chk(strobes - s0, 1);
    $display("timeout test done");
    // with the select low a complete write is ignored
    interface_select_pin = 1'b0;
    host_write(a, l, h, cks(a, l, h));
    chk(strobes - s0, 1);
    chk(replies - t0, 1);
    interface_select_pin = 1'b1;
    $display("deselect test done");
    end_of_test();
  end
endmodule // uart_register_access_port_tb
`default_nettype wire
